// ==== logic/wmg_defs.svh ====
/*
 * Timing counts, field positions and reset values for the waveform marker generator.
 * Assumes inclusion by its bare name from the package and design files.
 */
`ifndef WMG_DEFS_SVH
`define WMG_DEFS_SVH

// ----------------------------------------------------------------------
// Channel layout and command codes
// ----------------------------------------------------------------------
`define WMG_NUM_CH         4
`define WMG_CMD_W          3
`define WMG_CMD_SET_RANGE  3'h1
`define WMG_CMD_CLR_RANGE  3'h2
`define WMG_CMD_CLR_ALL    3'h3
`define WMG_CMD_SET_FIRST  3'h4
// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define WMG_POL_RESET      4'h0
`define WMG_ROUTE_RESET    8'h00
`define WMG_ROUTE_EVENT    2'h0
`define WMG_ROUTE_HOLD     2'h1
`define WMG_ROUTE_BLANK    2'h2
`define WMG_MARK_LAG       2
`define WMG_HOLD_MAX_MS    100
`define WMG_CLK_MHZ        125

`endif

// ==== logic/wmg_pkg.sv ====
/*
 * Types shared by the waveform marker generator files.
 * Assumes wmg_defs.svh is on the include path.
 */
`include "wmg_defs.svh"

package wmg_pkg;
   // ----------------------------------------------------------------------
   // Edit command and walker states
   // ----------------------------------------------------------------------
   typedef logic [`WMG_CMD_W-1:0] wmg_cmd_t;
   typedef enum logic [1:0] {
      WMG_IDLE,
      WMG_CLEAR,
      WMG_WALK
   } wmg_state_t;
endpackage

// ==== logic/wmg_delay.sv ====
/*
 * Fixed-length delay line for marker bits.
 * Assumes a single clock domain and asynchronous active-high reset.
 */
`timescale 1ns/1ps

module wmg_delay #(
   parameter int W = 4,
   parameter int D = 2
) (
   input  wire logic         mclk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] din_i,
   output logic      [W-1:0] dout_o
);
   // ----------------------------------------------------------------------
   // Shift register state
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [D-1:0][W-1:0] pipe;
   } wmg_dly_state_t;

   wmg_dly_state_t st_r;
   wmg_dly_state_t st_nxt;

   // Shift one stage per sample clock
   always_comb begin
      st_nxt = st_r;
      for (int i = D-1; i > 0; i--) begin
         st_nxt.pipe[i] = st_r.pipe[i-1];
      end
      st_nxt.pipe[0] = din_i;
   end

   // Registered stages; output is the last stage
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign dout_o = st_r.pipe[D-1];
endmodule

// ==== logic/wmg_top.sv ====
/*
 * Waveform marker generator: per-sample marker memory for four channels,
 * range/skip editing walker, playback with polarity, routing and delay.
 * Assumes the sample clock drives mclk_i, commands come from logic on the
 * same clock, and the level loop accepts a hold/sample and a blank level.
 */
`timescale 1ns/1ps
`include "wmg_defs.svh"

// Behaviour
// - Four independent marker channels, any sample point or set of points.
// - Setting points ORs into existing bits; earlier points are kept.
// - With no points set a positive-polarity event output rests low, a negative one high.
// - Clear-all resets one channel on every sample, other channels untouched.
// - Range-clear resets the channel from first to last point inclusive.
// - Range-set asserts the channel from first to last point inclusive.
// - Equal first and last points edit exactly one sample.
// - Set-first-point marks only the segment's first sample.
// - Skip N marks the first point then every (N+1)th up to last.
// - Marker output lags the waveform by at least two sample periods.
// - Hold routing holds the level loop at RMS of marker-high samples.
// - Level sampling happens whenever a hold-routed, polarity-adjusted marker is high.
// - Negative polarity drives low on marked, high on unmarked samples.
// - Positive polarity drives high on marked samples; default after preset.
// - Blank routing blanks output and holds the loop while marker is low.
// - Polarity and routing persist until rewritten, preset or reset.
module wmg_top #(
   parameter int AW  = 10,
   parameter int SW  = 16
) (
   input  wire logic                   mclk_i,
   input  wire logic                   rst_i,
   input  wire logic                   preset_i,
   input  wire logic                   cmd_valid_i,
   input  wire wmg_pkg::wmg_cmd_t      cmd_i,
   input  wire logic [1:0]             cmd_ch_i,
   input  wire logic [AW-1:0]          first_pt_i,
   input  wire logic [AW-1:0]          last_pt_i,
   input  wire logic [AW-1:0]          skip_i,
   input  wire logic [AW-1:0]          seg_len_i,
   input  wire logic                   cfg_we_i,
   input  wire logic [3:0]             pol_neg_i,
   input  wire logic [7:0]             route_i,
   input  wire logic                   play_i,
   input  wire logic [SW-1:0]          samp_i,
   output logic                        busy_o,
   output logic                        done_o,
   output logic [3:0]                  event_o,
   output logic [SW-1:0]               wave_o,
   output logic                        alc_sample_o,
   output logic                        alc_hold_o,
   output logic                        rf_blank_o,
   output logic [3:0]                  pol_neg_o,
   output logic [7:0]                  route_o
);
   import wmg_pkg::*;
   localparam int NCH = `WMG_NUM_CH;
   localparam int LAG = `WMG_MARK_LAG;
   localparam int DEP = 1 << AW;

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      wmg_state_t          fsm;
      logic [1:0]          ch;
      logic                set;
      logic [AW-1:0]       addr;
      logic [AW-1:0]       last;
      logic [AW-1:0]       skip;
      logic [AW-1:0]       gap;
      logic                busy;
      logic                done;
      logic [3:0]          pol;
      logic [7:0]          route;
      logic [AW-1:0]       rd;
      logic [SW-1:0]       wv0;
      logic [SW-1:0]       wave;
      logic [3:0]          ev;
      logic                asamp;
      logic                ahold;
      logic                blank;
   } wmg_state_s_t;

   wmg_state_s_t st_r;
   wmg_state_s_t st_nxt;

   logic [NCH-1:0] mem [DEP];  // Marker bits per sample point
   logic [NCH-1:0] mrk_rd;
   logic [NCH-1:0] mrk_dly;
   logic [NCH-1:0] lvl;
   logic           wr_en;
   logic [NCH-1:0] wr_data;

   // ----------------------------------------------------------------------
   // Edit walker and playback control
   // ----------------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      wr_en = 1'b0;
      wr_data = mem[st_r.addr];
      st_nxt.done = 1'b0;
      // Settings kept until rewritten or preset
      if (preset_i) begin
         st_nxt.pol = `WMG_POL_RESET;
         st_nxt.route = `WMG_ROUTE_RESET;
      end else if (cfg_we_i) begin
         st_nxt.pol = pol_neg_i;
         st_nxt.route = route_i;
      end
      case (st_r.fsm)
         WMG_IDLE: begin
            if (cmd_valid_i) begin
               st_nxt.ch = cmd_ch_i;
               st_nxt.skip = skip_i;
               st_nxt.gap = '0;
               st_nxt.last = last_pt_i;
               st_nxt.addr = first_pt_i;
               st_nxt.busy = 1'b1;
               case (cmd_i)
                  `WMG_CMD_SET_RANGE: begin
                     st_nxt.set = 1'b1;
                     st_nxt.fsm = WMG_WALK;
                  end
                  `WMG_CMD_CLR_RANGE: begin
                     st_nxt.set = 1'b0;
                     st_nxt.fsm = WMG_WALK;
                  end
                  `WMG_CMD_CLR_ALL: begin
                     st_nxt.set = 1'b0;
                     st_nxt.addr = '0;
                     st_nxt.last = seg_len_i - AW'(1);
                     st_nxt.fsm = WMG_CLEAR;
                  end
                  `WMG_CMD_SET_FIRST: begin
                     st_nxt.set = 1'b1;
                     st_nxt.skip = '0;
                     st_nxt.addr = '0;
                     st_nxt.last = '0;
                     st_nxt.fsm = WMG_WALK;
                  end
                  default: begin
                     st_nxt.busy = 1'b0;
                  end
               endcase
            end
         end
         WMG_CLEAR, WMG_WALK: begin
            // One point per cycle, inclusive of both ends
            if (st_r.fsm == WMG_CLEAR || st_r.set == 1'b0 || st_r.gap == '0) begin
               wr_en = 1'b1;
               wr_data[st_r.ch] = st_r.set;
            end
            if (st_r.gap == st_r.skip) begin
               st_nxt.gap = '0;
            end else begin
               st_nxt.gap = st_r.gap + AW'(1);
            end
            st_nxt.addr = st_r.addr + AW'(1);
            if (st_r.addr == st_r.last) begin
               st_nxt.fsm = WMG_IDLE;
               st_nxt.busy = 1'b0;
               st_nxt.done = 1'b1;
            end
         end
         default: begin
            st_nxt.fsm = WMG_IDLE;
            st_nxt.busy = 1'b0;
         end
      endcase
      // Playback address wraps at segment end
      if (play_i) begin
         if (st_r.rd + AW'(1) >= seg_len_i) begin
            st_nxt.rd = '0;
         end else begin
            st_nxt.rd = st_r.rd + AW'(1);
         end
      end else begin
         st_nxt.rd = '0;
      end
      // Waveform gets two stages; marker gets the read stage, LAG more and the output stage
      st_nxt.wv0 = samp_i;
      st_nxt.wave = st_r.wv0;
      st_nxt.ev = lvl;
      st_nxt.asamp = 1'b0;
      st_nxt.blank = 1'b0;
      for (int c = 0; c < NCH; c++) begin
         if (st_r.route[2*c +: 2] == `WMG_ROUTE_HOLD && lvl[c]) begin
            st_nxt.asamp = 1'b1;
         end
         if (st_r.route[2*c +: 2] == `WMG_ROUTE_BLANK && !lvl[c]) begin
            st_nxt.blank = 1'b1;
         end
      end
      // Level loop holds while a hold-routed marker is low or blanking is active
      st_nxt.ahold = st_nxt.blank;
      for (int c = 0; c < NCH; c++) begin
         if (st_r.route[2*c +: 2] == `WMG_ROUTE_HOLD && !lvl[c]) begin
            st_nxt.ahold = 1'b1;
         end
      end
   end

   // Marker memory; read with the sample it belongs to
   always_ff @(posedge mclk_i) begin
      if (wr_en) begin
         mem[st_r.addr] <= wr_data;
      end
      mrk_rd <= play_i ? mem[st_r.rd] : '0;
   end

   // Extra lag so markers trail the waveform
   wmg_delay #(
      .W (NCH),
      .D (LAG)
   ) u_dly (
      .mclk_i (mclk_i),
      .rst_i  (rst_i),
      .din_i  (mrk_rd),
      .dout_o (mrk_dly)
   );

   // Polarity: inverted level on negative channels
   assign lvl = mrk_dly ^ st_r.pol;

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         st_r <= '0;
         st_r.fsm <= WMG_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign busy_o       = st_r.busy;
   assign done_o       = st_r.done;
   assign event_o      = st_r.ev;
   assign wave_o       = st_r.wave;
   assign alc_sample_o = st_r.asamp;
   assign alc_hold_o   = st_r.ahold;
   assign rf_blank_o   = st_r.blank;
   assign pol_neg_o    = st_r.pol;
   assign route_o      = st_r.route;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   done_after_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (st_r.fsm != WMG_IDLE && st_r.addr == st_r.last) |=> done_o && !busy_o)
      else $error("done missing after last point");
   preset_pol_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      preset_i |=> pol_neg_o == 4'h0 && route_o == 8'h00)
      else $error("preset did not restore defaults");
   cfg_keep_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (!preset_i && !cfg_we_i) |=> $stable(pol_neg_o) && $stable(route_o))
      else $error("settings changed without write");
   idle_low_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (!play_i && pol_neg_o == 4'h0)[*4] |=> event_o == 4'h0)
      else $error("event output not low with no markers");
   event_pol_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      1'b1 |=> event_o == ($past(mrk_dly) ^ $past(pol_neg_o)))
      else $error("event level disagrees with polarity");
   blank_low_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      rf_blank_o |-> alc_hold_o)
      else $error("blanking without level hold");
   // Looks at the stored word after the write, so a wrong address or bit shows up
   write_or_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      wr_en |=> ((mem[$past(st_r.addr)] ^ $past(mem[st_r.addr]))
                 & ~(4'h1 << $past(st_r.ch))) == 4'h0
                && mem[$past(st_r.addr)][$past(st_r.ch)] == $past(st_r.set))
      else $error("edit touched another channel");
   first_only_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (st_r.fsm == WMG_IDLE && cmd_valid_i && cmd_i == `WMG_CMD_SET_FIRST)
      |=> st_r.addr == '0 ##1 done_o)
      else $error("set-first did not mark point zero only");
endmodule

// ==== verification/wmg_instr.sv ====
/*
 * Instrument model watching the event and level-loop outputs.
 * Assumes the sample clock is shared and marker 2 marks only sample 0.
 */
`timescale 1ns/1ps

module wmg_instr (
   input  wire logic        mclk_i,
   input  wire logic        en_i,
   input  wire logic [3:0]  event_i,
   input  wire logic [2:0]  lvl_i,
   output logic             obs_v_o,
   output logic [11:0]      obs_o
);
   logic       synced = 1'b0;
   logic [4:0] idx;

   // Lock on the sample-0 pulse, then report every sample with its index
   always @(posedge mclk_i) begin
      obs_v_o <= 1'b0;
      if (!en_i) begin
         synced <= 1'b0;
      end else if (event_i[2] === 1'b1) begin
         synced  <= 1'b1;
         idx     <= 5'h01;
         obs_v_o <= 1'b1;
         obs_o   <= {5'h00, event_i, lvl_i};
      end else if (synced) begin
         idx     <= idx + 5'h01; // Wraps with a 32-sample segment
         obs_v_o <= 1'b1;
         obs_o   <= {idx, event_i, lvl_i};
      end
   end
endmodule

// ==== verification/tb_wmg_top.sv ====
/*
 * Self-checking bench for the marker generator: edits, playback, settings.
 * Assumes a 32-sample segment and the instrument model beside the design.
 */
`timescale 1ns/1ps
`include "wmg_defs.svh"

module tb_wmg_top;
   import wmg_pkg::*;
   localparam int SEG = 32;
   logic             mclk_i = 1'b0, rst_i = 1'b1, preset_i = 1'b0, cmd_valid_i = 1'b0;
   logic             cfg_we_i = 1'b0, play_i = 1'b0, en = 1'b0, obs_v;
   wmg_cmd_t         cmd_i = 3'h0;
   logic [1:0]       cmd_ch_i = 2'h0;
   logic [9:0]       first_pt_i = 10'h000, last_pt_i = 10'h000, skip_i = 10'h000;
   logic [9:0]       seg_len_i = 10'h020;
   logic [3:0]       pol_neg_i = 4'h0, event_o, pol_neg_o, mdl [SEG];
   logic [7:0]       route_i = 8'h00, route_o;
   logic [15:0]      samp_i = 16'h0000, wave_o, h1, h2;
   logic             busy_o, done_o, alc_sample_o, alc_hold_o, rf_blank_o;
   logic [11:0]      obs, evq [$];
   int               fails = 0, samples_checked = 0, cyc = 0, seed = 55263, dq [$];

   wmg_top u_wmg_top (.mclk_i(mclk_i), .rst_i(rst_i), .preset_i(preset_i),
      .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ch_i(cmd_ch_i),
      .first_pt_i(first_pt_i), .last_pt_i(last_pt_i), .skip_i(skip_i),
      .seg_len_i(seg_len_i), .cfg_we_i(cfg_we_i), .pol_neg_i(pol_neg_i),
      .route_i(route_i), .play_i(play_i), .samp_i(samp_i), .busy_o(busy_o),
      .done_o(done_o), .event_o(event_o), .wave_o(wave_o), .alc_sample_o(alc_sample_o),
      .alc_hold_o(alc_hold_o), .rf_blank_o(rf_blank_o), .pol_neg_o(pol_neg_o),
      .route_o(route_o));
   wmg_instr u_wmg_instr (.mclk_i(mclk_i), .en_i(en), .event_i(event_o),
      .lvl_i({alc_sample_o, alc_hold_o, rf_blank_o}), .obs_v_o(obs_v), .obs_o(obs));

   // ----------------------------------------------------------------------
   // Clock, random samples, cycle count and hang guard
   // ----------------------------------------------------------------------
   always #4 mclk_i = ~mclk_i;
   always @(posedge mclk_i) begin
      #1 samp_i = $random(seed);
   end
   always @(posedge mclk_i) begin
      h1 <= samp_i;
      h2 <= h1;
      cyc <= cyc + 1;
      if (cyc > 6000) begin
         fails++;
         report_and_stop();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Settled values are read mid-cycle so edge ordering never matters
   always @(negedge mclk_i) begin
      if (done_o === 1'b1) begin
         if (dq.size() == 0) chk(1, 0);
         else chk(cyc, dq.pop_front());
      end
      if (obs_v === 1'b1 && evq.size() != 0) begin
         chk(obs, evq.pop_front());
         chk(wave_o, h2);
      end
   end

   // ----------------------------------------------------------------------
   // Edit command with model update; intr tries a second command while busy
   // ----------------------------------------------------------------------
   task automatic cmd(input wmg_cmd_t c, input int ch, input int f, input int l,
                      input int sk, input bit intr);
      int k;
      k = (c == `WMG_CMD_CLR_ALL) ? SEG : (c == `WMG_CMD_SET_FIRST) ? 1 : l - f + 1;
      cmd_i = c;
      cmd_ch_i = ch[1:0];
      first_pt_i = f[9:0];
      last_pt_i = l[9:0];
      skip_i = sk[9:0];
      cmd_valid_i = 1'b1;
      dq.push_back(cyc + k + 1);
      @(posedge mclk_i) #1 cmd_valid_i = 1'b0;
      if (intr) begin
         cmd_i = `WMG_CMD_SET_RANGE;
         cmd_ch_i = 2'h3;
         last_pt_i = SEG - 1;
         @(posedge mclk_i) #1 cmd_valid_i = 1'b1;
         @(posedge mclk_i) #1 cmd_valid_i = 1'b0;
      end
      for (int i = 0; i < SEG; i++) begin
         if (c == `WMG_CMD_CLR_ALL || (c == `WMG_CMD_CLR_RANGE && i >= f && i <= l))
            mdl[i][ch] = 1'b0;
         if ((c == `WMG_CMD_SET_FIRST && i == 0) ||
             (c == `WMG_CMD_SET_RANGE && i >= f && i <= l && (i - f) % (sk + 1) == 0))
            mdl[i][ch] = 1'b1;
      end
      for (int t = 0; t < SEG + 8 && dq.size() != 0; t++) @(posedge mclk_i);
      #1;
      if (dq.size() != 0) begin
         chk(dq.size(), 0);
         dq.delete();
      end
   endtask

   // Two full periods of playback under the given polarity and routing
   task automatic play(input logic [3:0] pol, input logic [7:0] rt);
      logic [3:0] ev;
      logic       hs, hl, bl;
      int         c0;
      pol_neg_i = pol;
      route_i = rt;
      cfg_we_i = 1'b1;
      @(posedge mclk_i) #1 cfg_we_i = 1'b0;
      chk(pol_neg_o, pol);
      chk(route_o, rt);
      for (int p = 0; p < 2 * SEG; p++) begin
         ev = mdl[p % SEG] ^ pol;
         hs = 1'b0;
         hl = 1'b0;
         bl = 1'b0;
         // Loop is held only by a low hold-routed marker or by blanking
         for (int j = 0; j < 4; j++) begin
            hs = hs | (ev[j] & (rt[2*j+:2] == `WMG_ROUTE_HOLD));
            hl = hl | (!ev[j] & (rt[2*j+:2] == `WMG_ROUTE_HOLD));
            bl = bl | (!ev[j] & (rt[2*j+:2] == `WMG_ROUTE_BLANK));
         end
         evq.push_back({p[4:0], ev, hs, hl | bl, bl});
      end
      play_i = 1'b1;
      en = 1'b1;
      c0 = cyc;
      // Marker 2 of sample 0 must trail the two-stage waveform path by the lag
      for (int t = 0; t < 16 && event_o[2] !== 1'b1; t++) @(negedge mclk_i);
      chk(cyc - c0, 2 + `WMG_MARK_LAG);
      for (int t = 0; t < 4 * SEG && evq.size() != 0; t++) @(posedge mclk_i);
      #1 chk(evq.size(), 0);
      evq.delete();
      play_i = 1'b0;
      en = 1'b0;
      $display("test play pol=%h route=%h done", pol, rt);
   endtask

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      repeat (16) @(posedge mclk_i);
      #1 rst_i = 1'b0;
      chk({event_o, pol_neg_o, route_o, busy_o}, 17'h0);
      for (int c = 0; c < 4; c++) cmd(`WMG_CMD_CLR_ALL, c, 0, 0, 0, c == 3);
      cmd_i = 3'h7;
      cmd_valid_i = 1'b1;
      @(posedge mclk_i) #1 cmd_valid_i = 1'b0;
      chk(busy_o, 0);
      $display("test clear done");
      cmd(`WMG_CMD_SET_RANGE, 0, 5, 5, 0, 0);
      cmd(`WMG_CMD_SET_RANGE, 0, 10, 20, 0, 0);
      cmd(`WMG_CMD_CLR_RANGE, 0, 13, 17, 3, 0);
      cmd(`WMG_CMD_CLR_RANGE, 0, 19, 19, 0, 0);
      cmd(`WMG_CMD_SET_RANGE, 1, 5, 25, 1, 0);
      cmd(`WMG_CMD_SET_RANGE, 1, 26, SEG - 1, 2, 0);
      cmd(`WMG_CMD_SET_FIRST, 2, 9, 20, 0, 0);
      cmd(`WMG_CMD_SET_RANGE, 0, 22 + {$random(seed)} % 6, 29, {$random(seed)} % 3, 0);
      $display("test edit done");
      play(4'h0, 8'h00);
      play(4'hB, 8'h09);
      preset_i = 1'b1;
      @(posedge mclk_i) #1 preset_i = 1'b0;
      chk({pol_neg_o, route_o}, 12'h0);
      cmd(`WMG_CMD_CLR_ALL, 1, 0, 0, 0, 0);
      play(4'h0, 8'h00);
      report_and_stop();
   end
endmodule
